/* File: rtl/pll_mode_pkg.sv */
// Contract
// - expose read-only part id and revision fields
// - digital loop off powers down input block
// - select 0xx gives analog-loop-only mode
// - select 11x plus loop on gives combined
// - analog-only mode disables monitors and filtering
// - analog-only locks crystal or any input clock
// - combined mode enables monitors, switching, filtering; the code enables them in the jitter sub-mode only
// - jitter sub-mode locks first three inputs
// - oscillator sub-mode: host writes output frequency
// - spread sub-mode sweeps frequency at rate/range
// - combined needs master clock field programmed
// - crystal master clock requires doubler enabled
// - device slave takes commands; master fetches memory
// - avoid doubler with oscillator in jitter sub-mode
package pll_mode_pkg;
	// device register offsets on the configuration link
	localparam logic [7:0] ADDR_IDENT_FIRST = 8'h00;
	localparam logic [7:0] ADDR_IDENT_SECOND = 8'h01;
	localparam logic [7:0] ADDR_LOOP_ENABLE = 8'h02;
	localparam logic [7:0] ADDR_ANALOG_CTRL3 = 8'h03;
	localparam logic [7:0] ADDR_MASTER_CFG2 = 8'h04;
	localparam logic [7:0] ADDR_SUB_MODE = 8'h05;
	localparam logic [7:0] ADDR_NCO_WORD = 8'h06;
	localparam logic [7:0] ADDR_SPREAD_RATE = 8'h07;
	localparam logic [7:0] ADDR_SPREAD_RANGE = 8'h08;
	localparam logic [7:0] ADDR_MODE_STATUS = 8'h09;
	// arbitrary identity values, no meaning beyond this design
	localparam logic [11:0] PART_ID = 12'h5a3;
	localparam logic [3:0] PART_REV = 4'h1;
	// master_config2 field positions
	localparam int MCFG_MCLK_LSB = 0;
	localparam int MCFG_DOUBLER_BIT = 2;
	localparam int MCFG_CRYSTAL_BIT = 3;
	// master clock choices: 100, 114.285 and 125 MHz
	localparam logic [1:0] MCLK_100 = 2'h0;
	localparam logic [1:0] MCLK_114 = 2'h1;
	localparam logic [1:0] MCLK_125 = 2'h2;
	// reset values
	localparam logic RST_LOOP_ENABLE = 1'h0;
	localparam logic [2:0] RST_INPUT_SELECT = 3'h0;
	localparam logic [3:0] RST_MASTER_CFG2 = 4'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// auto-configuration loads this many bytes into offsets 2 onward
	localparam logic [7:0] AUTO_BASE = 8'h02;
	localparam logic [7:0] AUTO_WORDS = 8'h07;
	// host AXI4-Lite register byte addresses
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STATUS = 8'h04;
	localparam int CMD_WRITE_BIT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SUB_JITTER, SUB_NCO, SUB_SPREAD} sub_mode_t;
	typedef enum logic [1:0] {AC_IDLE, AC_FETCH, AC_WAIT} auto_state_t;
	typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} host_state_t;
endpackage

/* File: rtl/pll_cfg_if.sv */
`timescale 1ns/1ps
// register link between configuring host and the mode controller
interface pll_cfg_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ready;
	logic rvalid;
	logic [7:0] rdata;

	modport device (input req, input we, input addr, input wdata,
		output ready, output rvalid, output rdata);
	modport host (output req, output we, output addr, output wdata,
		input ready, input rvalid, input rdata);
endinterface // pll_cfg_if

/* File: rtl/pll_mode_device.sv */
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pll_mode_device
(
	input wire logic aclk,
	input wire logic aresetn,
	pll_cfg_if.device link,
	input wire logic autoconfig_start,
	output logic mem_req,
	output logic [7:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic autoconfig_busy,
	output logic analog_only_mode,
	output logic combined_mode,
	output logic input_block_power,
	output logic digital_loop_power,
	output logic monitors_enable,
	output logic ref_switch_enable,
	output logic jitter_filter_enable,
	output logic [2:0] analog_ref_sel,
	output logic [1:0] digital_ref_sel,
	output logic [1:0] mclk_select,
	output logic doubler_enable,
	output logic nco_active,
	output logic [7:0] nco_word,
	output logic spread_active,
	output logic [7:0] spread_offset
);
	typedef struct packed {
		logic digital_loop_on;
		logic [2:0] analog_loop_input_select;
		logic [3:0] master_config2;
		pll_mode_pkg::sub_mode_t sub_mode;
		logic [7:0] nco;
		logic [7:0] rate;
		logic [7:0] range;
		logic rvalid;
		logic [7:0] rdata;
		pll_mode_pkg::auto_state_t ac;
		logic [7:0] ac_idx;
		logic [7:0] rate_cnt;
		logic [7:0] sweep;
		logic sweep_down;
	} dev_state_t;

	dev_state_t cur;
	dev_state_t next_cur;
	logic is_analog;
	logic is_combined;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_mux;

	// mode decode straight from the control fields
	always_comb
	begin
		is_analog = ~cur.analog_loop_input_select[2]
			| (cur.analog_loop_input_select[2:1] == 2'b10); // crystal
		is_combined = (cur.analog_loop_input_select[2:1] == 2'b11)
			& cur.digital_loop_on;
	end

	// the link is refused while the device is master on the memory port
	assign link.ready = (cur.ac == pll_mode_pkg::AC_IDLE);
	assign link.rvalid = cur.rvalid;
	assign link.rdata = cur.rdata;

	// one write source at a time: memory fetch or host command
	always_comb
	begin
		if (cur.ac == pll_mode_pkg::AC_WAIT)
		begin
			wr_en = mem_ack;
			wr_addr = 8'(pll_mode_pkg::AUTO_BASE + cur.ac_idx);
			wr_data = mem_rdata;
		end
		else
		begin
			wr_en = link.req & link.ready & link.we;
			wr_addr = link.addr;
			wr_data = link.wdata;
		end
	end

	// read decode; status exposes the resolved mode
	always_comb
	begin
		if (link.addr == pll_mode_pkg::ADDR_IDENT_FIRST)
			rd_mux = pll_mode_pkg::PART_ID[11:4];
		else if (link.addr == pll_mode_pkg::ADDR_IDENT_SECOND)
			rd_mux = {pll_mode_pkg::PART_ID[3:0], pll_mode_pkg::PART_REV};
		else if (link.addr == pll_mode_pkg::ADDR_LOOP_ENABLE)
			rd_mux = {7'h00, cur.digital_loop_on};
		else if (link.addr == pll_mode_pkg::ADDR_ANALOG_CTRL3)
			rd_mux = {5'h00, cur.analog_loop_input_select};
		else if (link.addr == pll_mode_pkg::ADDR_MASTER_CFG2)
			rd_mux = {4'h0, cur.master_config2};
		else if (link.addr == pll_mode_pkg::ADDR_SUB_MODE)
			rd_mux = {6'h00, cur.sub_mode};
		else if (link.addr == pll_mode_pkg::ADDR_NCO_WORD)
			rd_mux = cur.nco;
		else if (link.addr == pll_mode_pkg::ADDR_SPREAD_RATE)
			rd_mux = cur.rate;
		else if (link.addr == pll_mode_pkg::ADDR_SPREAD_RANGE)
			rd_mux = cur.range;
		else if (link.addr == pll_mode_pkg::ADDR_MODE_STATUS)
			rd_mux = {6'h00, is_combined, is_analog};
		else
			rd_mux = 8'h00; // unmapped reads as zero
	end

	// next state: register writes, auto-configuration, spread sweep
	always_comb
	begin
		next_cur = cur;
		next_cur.rvalid = 1'b0;
		// id offsets have no storage, so writes there fall through
		if (wr_en)
		begin
			if (wr_addr == pll_mode_pkg::ADDR_LOOP_ENABLE)
				next_cur.digital_loop_on = wr_data[0];
			else if (wr_addr == pll_mode_pkg::ADDR_ANALOG_CTRL3)
				next_cur.analog_loop_input_select = wr_data[2:0];
			else if (wr_addr == pll_mode_pkg::ADDR_MASTER_CFG2)
				next_cur.master_config2 = wr_data[3:0];
			else if (wr_addr == pll_mode_pkg::ADDR_SUB_MODE)
			begin
				// the unused code 3 falls back to jitter attenuation
				if (wr_data[1:0] == 2'h1)
					next_cur.sub_mode = pll_mode_pkg::SUB_NCO;
				else if (wr_data[1:0] == 2'h2)
					next_cur.sub_mode = pll_mode_pkg::SUB_SPREAD;
				else
					next_cur.sub_mode = pll_mode_pkg::SUB_JITTER;
			end
			else if (wr_addr == pll_mode_pkg::ADDR_NCO_WORD)
				next_cur.nco = wr_data;
			else if (wr_addr == pll_mode_pkg::ADDR_SPREAD_RATE)
				next_cur.rate = wr_data;
			else if (wr_addr == pll_mode_pkg::ADDR_SPREAD_RANGE)
				next_cur.range = wr_data;
		end
		if (link.req & link.ready & ~link.we)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rdata = rd_mux;
		end
		// auto-configuration: device drives addresses to external memory
		case (cur.ac)
			pll_mode_pkg::AC_IDLE:
			begin
				if (autoconfig_start)
				begin
					next_cur.ac = pll_mode_pkg::AC_FETCH;
					next_cur.ac_idx = 8'h00;
				end
			end
			pll_mode_pkg::AC_FETCH:
				next_cur.ac = pll_mode_pkg::AC_WAIT;
			pll_mode_pkg::AC_WAIT:
			begin
				if (mem_ack)
				begin
					next_cur.ac_idx = 8'(cur.ac_idx + 8'h01);
					if (cur.ac_idx == 8'(pll_mode_pkg::AUTO_WORDS - 8'h01))
						next_cur.ac = pll_mode_pkg::AC_IDLE;
					else
						next_cur.ac = pll_mode_pkg::AC_FETCH;
				end
			end
			default:
				next_cur.ac = pll_mode_pkg::AC_IDLE;
		endcase
		// triangle sweep between zero and range, one step per rate period
		if (is_combined && cur.sub_mode == pll_mode_pkg::SUB_SPREAD)
		begin
			if (cur.rate_cnt >= cur.rate)
			begin
				next_cur.rate_cnt = 8'h00;
				if (cur.sweep_down)
				begin
					if (cur.sweep == 8'h00)
						next_cur.sweep_down = 1'b0;
					else
						next_cur.sweep = 8'(cur.sweep - 8'h01);
				end
				else
				begin
					if (cur.sweep >= cur.range)
						next_cur.sweep_down = 1'b1;
					else
						next_cur.sweep = 8'(cur.sweep + 8'h01);
				end
			end
			else
				next_cur.rate_cnt = 8'(cur.rate_cnt + 8'h01);
		end
		else
		begin
			next_cur.rate_cnt = 8'h00;
			next_cur.sweep = 8'h00;
			next_cur.sweep_down = 1'b0;
		end
	end

	// single state register, synchronous active-low reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cur.digital_loop_on <= pll_mode_pkg::RST_LOOP_ENABLE;
			cur.analog_loop_input_select <= pll_mode_pkg::RST_INPUT_SELECT;
			cur.master_config2 <= pll_mode_pkg::RST_MASTER_CFG2;
			cur.sub_mode <= pll_mode_pkg::SUB_JITTER;
			cur.nco <= pll_mode_pkg::RST_BYTE;
			cur.rate <= pll_mode_pkg::RST_BYTE;
			cur.range <= pll_mode_pkg::RST_BYTE;
			cur.rvalid <= 1'b0;
			cur.rdata <= pll_mode_pkg::RST_BYTE;
			cur.ac <= pll_mode_pkg::AC_IDLE;
			cur.ac_idx <= pll_mode_pkg::RST_BYTE;
			cur.rate_cnt <= pll_mode_pkg::RST_BYTE;
			cur.sweep <= pll_mode_pkg::RST_BYTE;
			cur.sweep_down <= 1'b0;
		end
		else
			cur <= next_cur;
	end

	// memory port: one address per fetch, held until acknowledged
	assign mem_req = (cur.ac == pll_mode_pkg::AC_WAIT);
	assign mem_addr = cur.ac_idx;
	assign autoconfig_busy = (cur.ac != pll_mode_pkg::AC_IDLE);

	// power and feature gating per mode and sub-mode
	assign analog_only_mode = is_analog;
	assign combined_mode = is_combined;
	assign digital_loop_power = is_combined;
	// oscillator and spread sub-modes shut the input block down
	assign input_block_power = is_combined & (cur.sub_mode == pll_mode_pkg::SUB_JITTER);
	assign monitors_enable = input_block_power;
	assign ref_switch_enable = input_block_power;
	assign jitter_filter_enable = input_block_power;
	assign analog_ref_sel = cur.analog_loop_input_select;
	// digital loop only takes the first three inputs; code 3 clamps to c
	assign digital_ref_sel = (cur.analog_loop_input_select[1:0] == 2'h3) ? 2'h2
		: cur.analog_loop_input_select[1:0];
	assign mclk_select = cur.master_config2[pll_mode_pkg::MCFG_MCLK_LSB +: 2];
	assign doubler_enable = cur.master_config2[pll_mode_pkg::MCFG_DOUBLER_BIT];
	assign nco_active = is_combined & (cur.sub_mode == pll_mode_pkg::SUB_NCO);
	assign nco_word = cur.nco;
	assign spread_active = is_combined & (cur.sub_mode == pll_mode_pkg::SUB_SPREAD);
	assign spread_offset = cur.sweep;
endmodule // pll_mode_device

/* File: rtl/pll_mode_host.sv */
`timescale 1ns/1ps
module pll_mode_host
(
	input wire logic aclk,
	input wire logic aresetn,
	pll_cfg_if.host link,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef struct packed {
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		pll_mode_pkg::host_state_t st;
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] last_read;
		logic adjusted;
		logic [1:0] sub_shadow;
	} host_reg_t;

	host_reg_t cur;
	host_reg_t next_cur;
	logic [7:0] fix_data;

	// configuration hygiene on master_config2 before it leaves the host
	always_comb
	begin
		fix_data = cur.w_data[7:0];
		if (cur.w_data[15:8] == pll_mode_pkg::ADDR_MASTER_CFG2)
		begin
			if (cur.w_data[pll_mode_pkg::MCFG_CRYSTAL_BIT])
				fix_data[pll_mode_pkg::MCFG_DOUBLER_BIT] = 1'b1;
			// code 3 runs as jitter attenuation in the device, so it counts here too
			else if (cur.sub_shadow == 2'h0 || cur.sub_shadow == 2'h3)
				fix_data[pll_mode_pkg::MCFG_DOUBLER_BIT] = 1'b0;
		end
	end

	// bus slave and link master in one next-state process
	always_comb
	begin
		next_cur = cur;
		if (awvalid && awready)
		begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = wdata;
		end
		if (cur.aw_held && cur.w_held)
		begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = pll_mode_pkg::RESP_SLVERR;
			// a command while one is in flight is refused
			if (cur.aw_addr == pll_mode_pkg::HOST_CMD && cur.st == pll_mode_pkg::H_IDLE)
			begin
				next_cur.bresp = pll_mode_pkg::RESP_OKAY;
				next_cur.st = pll_mode_pkg::H_REQ;
				next_cur.we = cur.w_data[pll_mode_pkg::CMD_WRITE_BIT];
				next_cur.addr = cur.w_data[15:8];
				next_cur.data = fix_data;
				next_cur.adjusted = (fix_data != cur.w_data[7:0]);
				if (cur.w_data[pll_mode_pkg::CMD_WRITE_BIT]
					&& cur.w_data[15:8] == pll_mode_pkg::ADDR_SUB_MODE)
					next_cur.sub_shadow = cur.w_data[1:0];
			end
		end
		if (cur.bvalid && bready)
			next_cur.bvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = pll_mode_pkg::RESP_OKAY;
			if (araddr == pll_mode_pkg::HOST_CMD)
				next_cur.rdata = {15'h0000, cur.we, cur.addr, cur.data};
			else if (araddr == pll_mode_pkg::HOST_STATUS)
				next_cur.rdata = {16'h0000, cur.last_read, 6'h00, cur.adjusted,
					(cur.st != pll_mode_pkg::H_IDLE)};
			else
			begin
				next_cur.rdata = 32'h0000_0000;
				next_cur.rresp = pll_mode_pkg::RESP_SLVERR;
			end
		end
		else if (cur.rvalid && rready)
			next_cur.rvalid = 1'b0;
		// link master: commands, addresses and data toward the device
		case (cur.st)
			pll_mode_pkg::H_IDLE:
				next_cur.st = next_cur.st;
			pll_mode_pkg::H_REQ:
			begin
				if (link.ready)
					next_cur.st = cur.we ? pll_mode_pkg::H_IDLE : pll_mode_pkg::H_WAIT;
			end
			pll_mode_pkg::H_WAIT:
			begin
				if (link.rvalid)
				begin
					next_cur.last_read = link.rdata;
					next_cur.st = pll_mode_pkg::H_IDLE;
				end
			end
			default:
				next_cur.st = pll_mode_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// handshake outputs; data outputs straight from flops
	assign awready = ~cur.aw_held & ~cur.bvalid;
	assign wready = ~cur.w_held & ~cur.bvalid;
	assign arready = ~cur.rvalid;
	assign bvalid = cur.bvalid;
	assign bresp = cur.bresp;
	assign rvalid = cur.rvalid;
	assign rresp = cur.rresp;
	assign rdata = cur.rdata;
	// frequency words for the oscillator sub-mode go out as plain writes
	assign link.req = (cur.st == pll_mode_pkg::H_REQ);
	assign link.we = cur.we;
	assign link.addr = cur.addr;
	assign link.wdata = cur.data;
endmodule // pll_mode_host

/* File: tb/pll_mode_link_assertions.sv */
`timescale 1ns/1ps
// watches the register link between the host end and the device end
module pll_mode_link_checker
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ready,
	input wire logic rvalid,
	input wire logic [7:0] rdata
);
	logic [7:0] last_addr;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// offset of the last taken command, so read data can be tied to it
	always_ff @(posedge aclk)
	begin
		if (req && ready)
			last_addr <= addr;
	end
	read_answer_a: assert property (req && ready && !we |=> rvalid)
		else $error("read not answered one cycle after it was taken");
	write_silent_a: assert property (req && ready && we |=> !rvalid)
		else $error("write produced read data");
	rvalid_pulse_a: assert property (rvalid |=> !rvalid)
		else $error("read data held longer than one cycle");
	req_release_a: assert property (req && ready && !we |=> !req)
		else $error("host kept requesting after its read was taken");
	refused_hold_a: assert property (req && !ready |=> req && $stable(addr) && $stable(wdata))
		else $error("host changed a refused command");
	ident_first_a: assert property (rvalid && last_addr == pll_mode_pkg::ADDR_IDENT_FIRST
		|-> rdata == pll_mode_pkg::PART_ID[11:4])
		else $error("first identity byte wrong");
	ident_second_a: assert property (rvalid && last_addr == pll_mode_pkg::ADDR_IDENT_SECOND
		|-> rdata == {pll_mode_pkg::PART_ID[3:0], pll_mode_pkg::PART_REV})
		else $error("second identity byte wrong");
	mode_excl_a: assert property (rvalid && last_addr == pll_mode_pkg::ADDR_MODE_STATUS
		|-> rdata[1:0] != 2'h3)
		else $error("both modes reported at once");
	reset_ready_a: assert property ($rose(aresetn) |-> ready && !rvalid)
		else $error("link not idle after reset");
endmodule // pll_mode_link_checker

/* File: tb/pll_top_mode_control_tb_top.sv */
`timescale 1ns/1ps
module pll_top_mode_control_tb_top;
	logic aclk, aresetn, autoconfig_start, mem_req, autoconfig_busy;
	logic mem_ack = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic analog_only_mode, combined_mode, input_block_power, digital_loop_power;
	logic monitors_enable, ref_switch_enable, jitter_filter_enable, doubler_enable;
	logic nco_active, spread_active, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] mem_addr, nco_word, spread_offset, awaddr, araddr, v, mx;
	logic [2:0] analog_ref_sel;
	logic [1:0] digital_ref_sel, mclk_select, bresp, rresp, r;
	logic [31:0] wdata, rdata, st;
	logic [3:0] wstrb;
	logic [7:0] img [0:6];
	int error_cnt, comparisons;
	int cyc = 0;
	int stall = 0;
	pll_cfg_if pll_cfg_if_i();
	pll_mode_device pll_mode_device_i (.aclk(aclk), .aresetn(aresetn), .link(pll_cfg_if_i.device),
		.autoconfig_start(autoconfig_start), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .autoconfig_busy(autoconfig_busy),
		.analog_only_mode(analog_only_mode), .combined_mode(combined_mode),
		.input_block_power(input_block_power), .digital_loop_power(digital_loop_power),
		.monitors_enable(monitors_enable), .ref_switch_enable(ref_switch_enable),
		.jitter_filter_enable(jitter_filter_enable), .analog_ref_sel(analog_ref_sel),
		.digital_ref_sel(digital_ref_sel), .mclk_select(mclk_select),
		.doubler_enable(doubler_enable), .nco_active(nco_active), .nco_word(nco_word),
		.spread_active(spread_active), .spread_offset(spread_offset));
	pll_mode_host pll_mode_host_i (.aclk(aclk), .aresetn(aresetn), .link(pll_cfg_if_i.host),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	pll_mode_link_checker pll_mode_link_checker_i (.aclk(aclk), .aresetn(aresetn),
		.req(pll_cfg_if_i.req), .we(pll_cfg_if_i.we), .addr(pll_cfg_if_i.addr),
		.wdata(pll_cfg_if_i.wdata), .ready(pll_cfg_if_i.ready), .rvalid(pll_cfg_if_i.rvalid),
		.rdata(pll_cfg_if_i.rdata));
	// 100 ns clock
	initial
	begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	// memory answers after a two-cycle stall; data toggles when not answering
	always @(posedge aclk)
	begin
		mem_ack <= 0;
		mem_rdata <= ~mem_rdata;
		stall <= mem_req ? stall + 1 : 0;
		if (mem_req && !mem_ack && stall >= 2)
		begin
			mem_ack <= 1;
			mem_rdata <= img[mem_addr[2:0]];
			stall <= 0;
		end
	end
	// hang guard, generous against roughly 300 expected cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end
	task automatic miss(input string m);
		error_cnt++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) miss($sformatf("byte %h expected %h", g, e));
	endtask
	task automatic chk_bit(input logic g, input logic e);
		comparisons++;
		if (g !== e) miss($sformatf("flag %b expected %b", g, e));
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		comparisons++;
		if (g !== e) miss($sformatf("response %h expected %h", g, e));
	endtask
	// address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awready && !ad) begin ad = 1; awvalid <= 0; end
			if (wready && !wd) begin wd = 1; wvalid <= 0; end
		end
		do @(posedge aclk); while (!bvalid);
		rs = bresp;
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	// a link command goes out through the command word; status shows its end
	task automatic dev_op(input logic w, input logic [7:0] a, input logic [7:0] d);
		axi_wr(pll_mode_pkg::HOST_CMD, {15'h0000, w, a, d}, r);
		chk_resp(r, pll_mode_pkg::RESP_OKAY);
		do axi_rd(pll_mode_pkg::HOST_STATUS, st, r); while (st[0] !== 1'b0);
		v = st[15:8];
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		logic [2:0] s;
		logic ea, ec;
		error_cnt = 0; comparisons = 0;
		aresetn = 1'b0; autoconfig_start = 1'b0;
		awaddr = 8'h00; awvalid = 0; wdata = 32'h0000_0000; wstrb = 4'hf; wvalid = 0;
		bready = 0; araddr = 8'h00; arvalid = 0; rready = 0;
		img = '{8'h01, 8'h06, 8'h01, 8'h01, 8'h3c, 8'h00, 8'h00};
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		#1 chk_bit(analog_only_mode, 1'b1);
		chk_bit(digital_loop_power, 1'b0);
		// identity bytes are fixed and ignore writes
		dev_op(1'b1, pll_mode_pkg::ADDR_IDENT_FIRST, 8'hff);
		dev_op(1'b0, pll_mode_pkg::ADDR_IDENT_FIRST, 8'h00);
		chk_byte(v, pll_mode_pkg::PART_ID[11:4]);
		dev_op(1'b0, pll_mode_pkg::ADDR_IDENT_SECOND, 8'h00);
		chk_byte(v, {pll_mode_pkg::PART_ID[3:0], pll_mode_pkg::PART_REV});
		$display("test ident done");
		// every selector value with the digital loop on, jitter sub-mode
		dev_op(1'b1, pll_mode_pkg::ADDR_LOOP_ENABLE, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			s = i[2:0];
			ea = !s[2] || s[2:1] == 2'h2;
			ec = s[2:1] == 2'h3;
			dev_op(1'b1, pll_mode_pkg::ADDR_ANALOG_CTRL3, {5'h00, s});
			chk_bit(analog_only_mode, ea);
			chk_bit(combined_mode, ec);
			chk_byte({5'h00, analog_ref_sel}, {5'h00, s});
			chk_bit(monitors_enable, ec);
			chk_bit(jitter_filter_enable, ec);
			chk_bit(ref_switch_enable, ec);
			dev_op(1'b0, pll_mode_pkg::ADDR_MODE_STATUS, 8'h00);
			chk_byte(v, {6'h00, ec, ea});
		end
		chk_byte({6'h00, digital_ref_sel}, 8'h02);
		dev_op(1'b1, pll_mode_pkg::ADDR_LOOP_ENABLE, 8'h00);
		chk_bit(combined_mode, 1'b0);
		chk_bit(analog_only_mode, 1'b0);
		chk_bit(input_block_power, 1'b0);
		chk_bit(digital_loop_power, 1'b0);
		dev_op(1'b1, pll_mode_pkg::ADDR_LOOP_ENABLE, 8'h01);
		$display("test modes done");
		// oscillator sub-mode shuts the input block down; spread sub-mode sweep peaks at range
		dev_op(1'b1, pll_mode_pkg::ADDR_SUB_MODE, 8'h01);
		dev_op(1'b1, pll_mode_pkg::ADDR_NCO_WORD, 8'ha5);
		chk_bit(nco_active, 1'b1);
		chk_bit(input_block_power, 1'b0);
		chk_byte(nco_word, 8'ha5);
		dev_op(1'b1, pll_mode_pkg::ADDR_SPREAD_RATE, 8'h00);
		dev_op(1'b1, pll_mode_pkg::ADDR_SPREAD_RANGE, 8'h03);
		dev_op(1'b1, pll_mode_pkg::ADDR_SUB_MODE, 8'h02);
		chk_bit(spread_active, 1'b1);
		chk_bit(digital_loop_power, 1'b1);
		mx = 8'h00;
		repeat (24)
		begin
			@(posedge aclk);
			#1 if (spread_offset > mx) mx = spread_offset;
		end
		chk_byte(mx, 8'h03);
		$display("test sub-modes done");
		// master clock field, doubler forced by crystal, cleared for oscillator jitter use
		dev_op(1'b1, pll_mode_pkg::ADDR_MASTER_CFG2, 8'h0a);
		chk_bit(st[1], 1'b1);
		chk_byte({6'h00, mclk_select}, 8'h02);
		chk_bit(doubler_enable, 1'b1);
		dev_op(1'b1, pll_mode_pkg::ADDR_SUB_MODE, 8'h00);
		chk_bit(st[1], 1'b0);
		// unused sub-mode code falls back to jitter attenuation
		dev_op(1'b1, pll_mode_pkg::ADDR_SUB_MODE, 8'h03);
		dev_op(1'b0, pll_mode_pkg::ADDR_SUB_MODE, 8'h00);
		chk_byte(v, 8'h00);
		dev_op(1'b1, pll_mode_pkg::ADDR_MASTER_CFG2, 8'h05);
		chk_bit(st[1], 1'b1);
		chk_byte({6'h00, mclk_select}, 8'h01);
		chk_bit(doubler_enable, 1'b0);
		$display("test master clock done");
		// auto-configuration refuses the link; host holds and then completes
		@(posedge aclk);
		autoconfig_start <= 1;
		@(posedge aclk);
		autoconfig_start <= 0;
		#1 chk_bit(autoconfig_busy, 1'b1);
		axi_wr(pll_mode_pkg::HOST_CMD, {15'h0000, 1'b0, pll_mode_pkg::ADDR_NCO_WORD, 8'h00}, r);
		chk_resp(r, pll_mode_pkg::RESP_OKAY);
		axi_wr(pll_mode_pkg::HOST_CMD, 32'h0001_0201, r);
		chk_resp(r, pll_mode_pkg::RESP_SLVERR);
		do axi_rd(pll_mode_pkg::HOST_STATUS, st, r); while (st[0] !== 1'b0);
		chk_byte(st[15:8], 8'h3c);
		chk_bit(nco_active, 1'b1);
		chk_byte({6'h00, mclk_select}, 8'h01);
		chk_bit(mem_req, 1'b0);
		chk_bit(autoconfig_busy, 1'b0);
		// command word reads back the last accepted command, not the refused one
		axi_rd(pll_mode_pkg::HOST_CMD, st, r);
		chk_resp(r, pll_mode_pkg::RESP_OKAY);
		chk_bit(st[16], 1'b0);
		chk_byte(st[15:8], pll_mode_pkg::ADDR_NCO_WORD);
		// unmapped host address
		axi_wr(8'h10, 32'h0000_0001, r);
		chk_resp(r, pll_mode_pkg::RESP_SLVERR);
		axi_rd(8'h10, st, r);
		chk_resp(r, pll_mode_pkg::RESP_SLVERR);
		chk_byte(st[7:0], 8'h00);
		$display("test autoconfig done");
		close_out();
	end
endmodule // pll_top_mode_control_tb_top
